// ==== common/otsc_pkg.sv ====
// shared constants, types and register map of the overtravel stop control
package otsc_pkg;

  // ******************************
  // bus and widths
  // ******************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int TQ_W   = 9;
  localparam int EV_W   = 4;

  // ******************************
  // register offsets (byte addresses)
  // ******************************
  localparam logic [7:0] OFS_BASIC_FUNC = 8'h00;
  localparam logic [7:0] OFS_STOP_METH  = 8'h04;
  localparam logic [7:0] OFS_PLUG_TQ    = 8'h08;
  localparam logic [7:0] OFS_RATED_TQ   = 8'h0C;
  localparam logic [7:0] OFS_STATUS     = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT   = 8'h14;
  localparam logic [7:0] OFS_IRQ_EN     = 8'h18;
  localparam logic [7:0] OFS_IRQ_CLR    = 8'h1C;

  // ******************************
  // field positions
  // ******************************
  localparam int BF_FWD_DIS_BIT = 1;
  localparam int BF_REV_DIS_BIT = 2;
  localparam int SM_LSB         = 0;
  localparam int SM_W           = 3;
  localparam int ST_STATE_LSB   = 0;
  localparam int ST_DRIVE_LSB   = 4;
  localparam int ST_FLAGS_LSB   = 8;
  localparam int ST_MODE_LSB    = 12;
  localparam int ST_CFG_LSB     = 16;

  // event bits of the interrupt status
  localparam int EV_FWD_TRIP = 0;
  localparam int EV_REV_TRIP = 1;
  localparam int EV_STOPPED  = 2;
  localparam int EV_ERR_CLR  = 3;

  // ******************************
  // values
  // ******************************
  localparam logic [TQ_W-1:0] TQ_MAX      = 9'h12C;
  localparam logic [TQ_W-1:0] TQ_RESET    = 9'h12C;
  localparam logic [TQ_W-1:0] RATED_RESET = 9'h12C;
  localparam logic [SM_W-1:0] SM_DBRAKE   = 3'h0;
  localparam logic [SM_W-1:0] SM_COAST    = 3'h1;
  localparam logic [SM_W-1:0] SM_CLAMP_DB = 3'h4;
  localparam logic [SM_W-1:0] SM_CLAMP_CS = 3'h5;
  localparam logic [1:0]      MODE_POS    = 2'h1;

  // ******************************
  // types
  // ******************************
  typedef struct packed {
    logic            fwdDisable;
    logic            revDisable;
    logic [SM_W-1:0] stopMethod;
  } otsc_cfg_t;

  localparam otsc_cfg_t CFG_RESET = '{fwdDisable: 1'b0, revDisable: 1'b0, stopMethod: 3'h0};

  typedef enum logic [2:0] {
    ST_RUN, ST_STOP_DB, ST_STOP_COAST, ST_STOP_PLUG, ST_POST_COAST, ST_CLAMP
  } otsc_state_t;

  typedef enum logic [2:0] {
    DRV_RUN, DRV_DBRAKE, DRV_COAST, DRV_PLUG, DRV_CLAMP
  } otsc_drive_t;

endpackage

// ==== hw/otsc_torque_clip.sv ====
// plug braking torque limit clipped to the motor rating
`timescale 1ns/100ps
module otsc_torque_clip (
  input  wire logic                      clk,
  input  wire logic                      reset_n,
  input  wire logic [otsc_pkg::TQ_W-1:0] setPct,
  input  wire logic [otsc_pkg::TQ_W-1:0] ratedPct,
  output logic      [otsc_pkg::TQ_W-1:0] limitPct
);

  logic [otsc_pkg::TQ_W-1:0] capPct;
  logic [otsc_pkg::TQ_W-1:0] limitPct_next;

  // percent of rated torque, never past the range top nor the motor rating
  assign capPct        = (setPct > otsc_pkg::TQ_MAX) ? otsc_pkg::TQ_MAX : setPct;
  assign limitPct_next = (capPct > ratedPct) ? ratedPct : capPct;

  // new setting takes effect on the next edge, no power cycle needed
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      limitPct <= otsc_pkg::TQ_RESET;
    end else begin
      limitPct <= limitPct_next;
    end
  end

  tq_clip_a: assert property (@(posedge clk) disable iff (!reset_n)
    ##1 (limitPct <= $past(ratedPct)) && (limitPct <= otsc_pkg::TQ_MAX))
    else $error("torque limit above rating");

endmodule

// ==== hw/otsc_irq_ctrl.sv ====
// sticky event status with enable mask and one level interrupt
`timescale 1ns/100ps
module otsc_irq_ctrl #(
  parameter int W = 4
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] evt,
  input  wire logic [W-1:0] clr,
  input  wire logic [W-1:0] enable,
  output logic      [W-1:0] status,
  output logic              irq
);

  logic [W-1:0] status_next;

  // per bit: a new event beats a clear in the same cycle
  for (genvar i = 0; i < W; i++) begin : g_bit
    assign status_next[i] = evt[i] || (status[i] && !clr[i]);
  end

  // one process owns the whole word, so no bit has two writers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status <= '0;
    end else begin
      status <= status_next;
    end
  end

  // level output, follows status one cycle later
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & enable);
    end
  end

endmodule

// ==== hw/otsc_overtravel_ctrl.sv ====
// overtravel limit and stop method control of a servo drive
//
// Functional notes
// - forward limit high blocks forward rotation
// - reverse limit high blocks reverse rotation
// - forward disable bit ignores forward limit
// - reverse disable bit ignores reverse limit
// - checking runs in every control mode
// - limit and stop settings load on power cycle
// - position error kept until clear input
// - method 0: dynamic brake, then coast
// - method 1: coast stop, then coast
// - methods 2-5 plug brake; servo off differs
// - methods 4,5 clamp after stop; 2,3 coast
// - zero clamp holds position at zero reference
// - plug braking uses the torque limit
// - torque limit 0..300, default 300, immediate
// - torque limit is percent of rated
// - torque limit clipped to motor rating
//
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/100ps
module otsc_overtravel_ctrl (
  input  wire logic                        clk,
  input  wire logic                        reset_n,
  input  wire logic [otsc_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [otsc_pkg::DATA_W-1:0] regWrData,
  input  wire logic                        regWrite,
  input  wire logic                        regRead,
  output logic      [otsc_pkg::DATA_W-1:0] regRdData,
  input  wire logic                        fwdLimitIn,
  input  wire logic                        revLimitIn,
  input  wire logic                        posErrorClearIn,
  input  wire logic                        servoOn,
  input  wire logic                        motorMoving,
  input  wire logic [1:0]                  motionRequest,
  input  wire logic [1:0]                  controlMode,
  input  wire logic                        powerCycleDone,
  output logic                             fwdPermit,
  output logic                             revPermit,
  output otsc_pkg::otsc_drive_t            driveMode,
  output logic      [otsc_pkg::TQ_W-1:0]   torqueLimit,
  output logic                             posErrorHold,
  output logic                             irq
);

  // ******************************
  // declarations
  // ******************************
  otsc_pkg::otsc_cfg_t       pendCfg_reg;
  otsc_pkg::otsc_cfg_t       actCfg_reg;
  otsc_pkg::otsc_cfg_t       wrCfg;
  logic [otsc_pkg::TQ_W-1:0] plugTq_reg;
  logic [otsc_pkg::TQ_W-1:0] ratedTq_reg;
  logic [otsc_pkg::EV_W-1:0] irqEn_reg;
  logic [otsc_pkg::EV_W-1:0] irqStatus;
  logic [otsc_pkg::EV_W-1:0] events;
  logic [otsc_pkg::EV_W-1:0] irqClr;
  logic [otsc_pkg::TQ_W-1:0] wrTq;
  otsc_pkg::otsc_state_t     state_reg;
  otsc_pkg::otsc_state_t     state_next;
  otsc_pkg::otsc_drive_t     driveMode_next;
  otsc_pkg::otsc_drive_t     soffMode;
  logic [otsc_pkg::DATA_W-1:0] rdMux;
  logic [otsc_pkg::DATA_W-1:0] statusWord;
  logic                      wrBasic;
  logic                      wrMethod;
  logic                      wrPlug;
  logic                      wrRated;
  logic                      wrIrqEn;
  logic                      wrIrqClr;
  logic                      fwdOt;
  logic                      revOt;
  logic                      anyOt;
  logic                      trip;
  logic                      stopping;
  logic                      stopDone;
  logic                      clampAfter;
  logic                      leaveLimit;
  logic                      holdSet;
  logic                      fwdPermit_next;
  logic                      revPermit_next;
  logic                      posErrorHold_next;

  // ******************************
  // register decode
  // ******************************

  // address decode; every strobe is a single cycle
  assign wrBasic  = regWrite && (regAddr == otsc_pkg::OFS_BASIC_FUNC);
  assign wrMethod = regWrite && (regAddr == otsc_pkg::OFS_STOP_METH);
  assign wrPlug   = regWrite && (regAddr == otsc_pkg::OFS_PLUG_TQ);
  assign wrRated  = regWrite && (regAddr == otsc_pkg::OFS_RATED_TQ);
  assign wrIrqEn  = regWrite && (regAddr == otsc_pkg::OFS_IRQ_EN);
  assign wrIrqClr = regWrite && (regAddr == otsc_pkg::OFS_IRQ_CLR);
  assign irqClr   = wrIrqClr ? regWrData[otsc_pkg::EV_W-1:0] : '0;
  assign wrTq     = regWrData[otsc_pkg::TQ_W-1:0];

  // merge of the pending settings with a write to either field
  assign wrCfg.fwdDisable = wrBasic ? regWrData[otsc_pkg::BF_FWD_DIS_BIT]
                                    : pendCfg_reg.fwdDisable;
  assign wrCfg.revDisable = wrBasic ? regWrData[otsc_pkg::BF_REV_DIS_BIT]
                                    : pendCfg_reg.revDisable;
  assign wrCfg.stopMethod = wrMethod ? regWrData[otsc_pkg::SM_LSB +: otsc_pkg::SM_W]
                                     : pendCfg_reg.stopMethod;

  // ******************************
  // settings
  // ******************************

  // written values wait here; the running copy moves only on a power
  // cycle, so a stop already under way never changes method midway
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pendCfg_reg <= otsc_pkg::CFG_RESET;
      actCfg_reg  <= otsc_pkg::CFG_RESET;
    end else begin
      pendCfg_reg <= wrCfg;
      if (powerCycleDone) begin
        actCfg_reg <= pendCfg_reg;
      end
    end
  end

  // torque settings apply at once; rating is the motor's percent ceiling
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      plugTq_reg  <= otsc_pkg::TQ_RESET;
      ratedTq_reg <= otsc_pkg::RATED_RESET;
      irqEn_reg   <= '0;
    end else begin
      if (wrPlug) begin
        plugTq_reg <= (wrTq > otsc_pkg::TQ_MAX) ? otsc_pkg::TQ_MAX : wrTq;
      end
      if (wrRated) begin
        ratedTq_reg <= wrTq;
      end
      if (wrIrqEn) begin
        irqEn_reg <= regWrData[otsc_pkg::EV_W-1:0];
      end
    end
  end

  // ******************************
  // limit evaluation
  // ******************************

  // no control mode input here: checking is the same in every mode
  assign fwdOt = fwdLimitIn && !actCfg_reg.fwdDisable;
  assign revOt = revLimitIn && !actCfg_reg.revDisable;
  assign anyOt = fwdOt || revOt;

  // each direction only looks at its own switch
  assign fwdPermit_next = !fwdOt;
  assign revPermit_next = !revOt;

  // a stop starts only while powered and turning, in either direction, with either limit tripped
  assign trip       = (state_reg == otsc_pkg::ST_RUN) && servoOn && motorMoving && anyOt;
  assign stopping   = (state_reg == otsc_pkg::ST_STOP_DB) ||
                      (state_reg == otsc_pkg::ST_STOP_COAST) ||
                      (state_reg == otsc_pkg::ST_STOP_PLUG);
  assign stopDone   = stopping && !motorMoving;
  assign clampAfter = (actCfg_reg.stopMethod == otsc_pkg::SM_CLAMP_DB) ||
                      (actCfg_reg.stopMethod == otsc_pkg::SM_CLAMP_CS);

  // back off the switch: limits clear, or motion asked only in a free way
  assign leaveLimit = !anyOt ||
                      (servoOn && (motionRequest != 2'h0) &&
                       !(motionRequest[0] && fwdOt) && !(motionRequest[1] && revOt));

  // ******************************
  // stop sequencer
  // ******************************

  // next state; stop method chosen from the running copy
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      otsc_pkg::ST_RUN: begin
        if (trip) begin
          if (actCfg_reg.stopMethod == otsc_pkg::SM_DBRAKE) begin
            state_next = otsc_pkg::ST_STOP_DB;
          end else if (actCfg_reg.stopMethod == otsc_pkg::SM_COAST) begin
            state_next = otsc_pkg::ST_STOP_COAST;
          end else begin
            state_next = otsc_pkg::ST_STOP_PLUG;
          end
        end
      end
      otsc_pkg::ST_STOP_DB,
      otsc_pkg::ST_STOP_COAST: begin
        if (!motorMoving) begin
          state_next = otsc_pkg::ST_POST_COAST;
        end
      end
      otsc_pkg::ST_STOP_PLUG: begin
        if (!motorMoving) begin
          state_next = clampAfter ? otsc_pkg::ST_CLAMP : otsc_pkg::ST_POST_COAST;
        end
      end
      otsc_pkg::ST_POST_COAST,
      otsc_pkg::ST_CLAMP: begin
        if (leaveLimit) begin
          state_next = otsc_pkg::ST_RUN;
        end
      end
      default: begin
        state_next = otsc_pkg::ST_RUN;
      end
    endcase
  end

  // servo off alone: even methods brake, odd ones coast
  assign soffMode = actCfg_reg.stopMethod[0] ? otsc_pkg::DRV_COAST
                                             : otsc_pkg::DRV_DBRAKE;

  // drive output follows the state being entered
  always_comb begin
    driveMode_next = otsc_pkg::DRV_COAST;
    case (state_next)
      otsc_pkg::ST_RUN: begin
        driveMode_next = servoOn ? otsc_pkg::DRV_RUN : soffMode;
      end
      otsc_pkg::ST_STOP_DB: begin
        driveMode_next = otsc_pkg::DRV_DBRAKE;
      end
      otsc_pkg::ST_STOP_COAST: begin
        driveMode_next = otsc_pkg::DRV_COAST;
      end
      otsc_pkg::ST_STOP_PLUG: begin
        driveMode_next = otsc_pkg::DRV_PLUG;
      end
      otsc_pkg::ST_CLAMP: begin
        driveMode_next = otsc_pkg::DRV_CLAMP;
      end
      default: begin
        driveMode_next = otsc_pkg::DRV_COAST;
      end
    endcase
  end

  // ******************************
  // position error retention
  // ******************************

  // error pulses stay put until the controller clears them; a new trip
  // in the clearing cycle wins so its error is not silently dropped
  assign holdSet = trip && (controlMode == otsc_pkg::MODE_POS);
  assign posErrorHold_next = holdSet || (posErrorHold && !posErrorClearIn);

  // ******************************
  // state and output flops
  // ******************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg    <= otsc_pkg::ST_RUN;
      driveMode    <= otsc_pkg::DRV_RUN;
      fwdPermit    <= 1'b1;
      revPermit    <= 1'b1;
      posErrorHold <= 1'b0;
    end else begin
      state_reg    <= state_next;
      driveMode    <= driveMode_next;
      fwdPermit    <= fwdPermit_next;
      revPermit    <= revPermit_next;
      posErrorHold <= posErrorHold_next;
    end
  end

  // ******************************
  // torque limit and interrupts
  // ******************************

  // limit is always presented; the motor loop uses it while plug braking
  otsc_torque_clip u_clip (
    .clk      (clk),
    .reset_n  (reset_n),
    .setPct   (plugTq_reg),
    .ratedPct (ratedTq_reg),
    .limitPct (torqueLimit)
  );

  // events seen by software
  assign events[otsc_pkg::EV_FWD_TRIP] = trip && fwdOt;
  assign events[otsc_pkg::EV_REV_TRIP] = trip && revOt;
  assign events[otsc_pkg::EV_STOPPED]  = stopDone;
  assign events[otsc_pkg::EV_ERR_CLR]  = posErrorHold && posErrorClearIn;

  otsc_irq_ctrl #(
    .W (otsc_pkg::EV_W)
  ) u_irq (
    .clk     (clk),
    .reset_n (reset_n),
    .evt     (events),
    .clr     (irqClr),
    .enable  (irqEn_reg),
    .status  (irqStatus),
    .irq     (irq)
  );

  // ******************************
  // read path
  // ******************************

  // live state for software: state, drive mode, limit flags, mode, config
  assign statusWord = {11'h000,
                       actCfg_reg,
                       2'h0, controlMode,
                       1'b0, posErrorHold, revOt, fwdOt,
                       1'b0, driveMode,
                       1'b0, state_reg};

  // unmapped and write-only offsets read as zero
  always_comb begin
    rdMux = '0;
    case (regAddr)
      otsc_pkg::OFS_BASIC_FUNC: begin
        rdMux[otsc_pkg::BF_FWD_DIS_BIT] = pendCfg_reg.fwdDisable;
        rdMux[otsc_pkg::BF_REV_DIS_BIT] = pendCfg_reg.revDisable;
      end
      otsc_pkg::OFS_STOP_METH: begin
        rdMux[otsc_pkg::SM_LSB +: otsc_pkg::SM_W] = pendCfg_reg.stopMethod;
      end
      otsc_pkg::OFS_PLUG_TQ: begin
        rdMux[otsc_pkg::TQ_W-1:0] = plugTq_reg;
      end
      otsc_pkg::OFS_RATED_TQ: begin
        rdMux[otsc_pkg::TQ_W-1:0] = ratedTq_reg;
      end
      otsc_pkg::OFS_STATUS: begin
        rdMux = statusWord;
      end
      otsc_pkg::OFS_IRQ_STAT: begin
        rdMux[otsc_pkg::EV_W-1:0] = irqStatus;
      end
      otsc_pkg::OFS_IRQ_EN: begin
        rdMux[otsc_pkg::EV_W-1:0] = irqEn_reg;
      end
      default: begin
        rdMux = '0;
      end
    endcase
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      regRdData <= '0;
    end else begin
      regRdData <= regRead ? rdMux : '0;
    end
  end

  // ******************************
  // checks
  // ******************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  fwd_block_a: assert property (fwdLimitIn && !actCfg_reg.fwdDisable |=> !fwdPermit)
    else $error("forward not blocked on limit");

  fwd_ignore_a: assert property (actCfg_reg.fwdDisable |=> fwdPermit)
    else $error("forward blocked though disabled");

  rev_block_a: assert property (revLimitIn && !actCfg_reg.revDisable |=> !revPermit)
    else $error("reverse not blocked on limit");

  rev_ignore_a: assert property (actCfg_reg.revDisable |=> revPermit)
    else $error("reverse blocked though disabled");

  opposite_free_a: assert property (fwdLimitIn && !revLimitIn |=> revPermit)
    else $error("opposite direction blocked");

  cfg_hold_a: assert property (!powerCycleDone |=> $stable(actCfg_reg))
    else $error("settings changed without power cycle");

  err_keep_a: assert property (posErrorHold && !posErrorClearIn |=> posErrorHold)
    else $error("position error dropped early");

  db_stop_a: assert property (trip && actCfg_reg.stopMethod == otsc_pkg::SM_DBRAKE
    |=> driveMode == otsc_pkg::DRV_DBRAKE ##0 state_reg == otsc_pkg::ST_STOP_DB)
    else $error("method 0 not braking");

  coast_stop_a: assert property (trip && actCfg_reg.stopMethod == otsc_pkg::SM_COAST
    |=> driveMode == otsc_pkg::DRV_COAST)
    else $error("method 1 not coasting");

  plug_stop_a: assert property (trip && actCfg_reg.stopMethod > otsc_pkg::SM_COAST
    |=> driveMode == otsc_pkg::DRV_PLUG)
    else $error("plug braking not used");

  clamp_after_a: assert property (state_reg == otsc_pkg::ST_STOP_PLUG && !motorMoving
    |=> driveMode == (clampAfter ? otsc_pkg::DRV_CLAMP : otsc_pkg::DRV_COAST))
    else $error("wrong mode after stop");

endmodule

// ==== tb/otsc_limit_switch_model.sv ====
// limit switch pair as seen from the drive's connector
`timescale 1ns/100ps
module otsc_limit_switch_model #(
  parameter int SLOW = 0
) (
  input  wire logic clk,
  input  wire logic fwdPress,
  input  wire logic revPress,
  output logic      fwdLimitIn,
  output logic      revLimitIn
);
  logic [1:0] travel;

  // contact follows the actuator one cycle late; SLOW adds a cycle of travel
  // so a lazy contact can be modelled without touching the bench
  always_ff @(posedge clk) begin
    travel     <= {revPress, fwdPress};
    fwdLimitIn <= (SLOW != 0) ? travel[0] : fwdPress;
    revLimitIn <= (SLOW != 0) ? travel[1] : revPress;
  end
endmodule

// ==== tb/tb_overtravel_stop_control.sv ====
// self-checking bench of the overtravel stop control
`timescale 1ns/100ps
module tb_overtravel_stop_control;
  logic                  clk, reset_n, regWrite, regRead, errClr, servoOn, moving, pcd;
  logic                  fwdPress, revPress, fwdLimitIn, revLimitIn, rdPend;
  logic                  fwdPermit, revPermit, posErrorHold, irq;
  logic [7:0]            regAddr;
  logic [31:0]           regWrData, regRdData, rng;
  logic [1:0]            motionRequest, controlMode;
  logic [8:0]            torqueLimit, plug, rated, expTq;
  otsc_pkg::otsc_drive_t driveMode, expMode;
  logic [31:0]           rdQ[$];
  int                    mismatches = 0;
  int                    samples_checked = 0;

  otsc_overtravel_ctrl i_dut (.clk(clk), .reset_n(reset_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .fwdLimitIn(fwdLimitIn), .revLimitIn(revLimitIn), .posErrorClearIn(errClr),
    .servoOn(servoOn), .motorMoving(moving), .motionRequest(motionRequest),
    .controlMode(controlMode), .powerCycleDone(pcd), .fwdPermit(fwdPermit),
    .revPermit(revPermit), .driveMode(driveMode), .torqueLimit(torqueLimit),
    .posErrorHold(posErrorHold), .irq(irq));

  otsc_limit_switch_model i_sw (.clk(clk), .fwdPress(fwdPress), .revPress(revPress),
    .fwdLimitIn(fwdLimitIn), .revLimitIn(revLimitIn));

  // ******************************
  // clock and helpers
  // ******************************
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regWrite  <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask

  // expected read data is queued; the monitor below takes it off in order
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    rdQ.push_back(exp);
    @(posedge clk);
    regRead <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    if (rdPend) cmp(regRdData, rdQ.pop_front());
    rdPend <= regRead;
  end

  task automatic pulse_supply;
    @(posedge clk);
    pcd <= 1'b1;
    @(posedge clk);
    pcd <= 1'b0;
  endtask

  // switch model adds a cycle, so outputs are looked at three edges on
  task automatic drv(input logic f, input logic r, input logic s, input logic m);
    @(posedge clk);
    fwdPress <= f;
    revPress <= r;
    servoOn  <= s;
    moving   <= m;
    settle(3);
  endtask

  task automatic do_reset;
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ******************************
  // tests
  // ******************************
  initial begin
    {regWrite, regRead, errClr, servoOn, moving, pcd, fwdPress, revPress} = 8'h00;
    {regAddr, regWrData, rdPend} = 41'h0;
    motionRequest = 2'h1;
    controlMode = 2'h0;
    rng = 32'h8F3B;
    reset_n = 1'b0;
    do_reset;
    rd(otsc_pkg::OFS_PLUG_TQ, 32'h12C);
    rd(8'h40, 32'h0);
    wr(8'h40, 32'hFFFF);
    rd(8'h40, 32'h0);
    drv(1'b1, 1'b0, 1'b0, 1'b0);
    cmp(32'({fwdPermit, revPermit}), 32'h1);
    drv(1'b0, 1'b1, 1'b0, 1'b0);
    cmp(32'({fwdPermit, revPermit}), 32'h2);
    wr(otsc_pkg::OFS_BASIC_FUNC, 32'h6);
    drv(1'b1, 1'b1, 1'b0, 1'b0);
    cmp(32'({fwdPermit, revPermit}), 32'h0);
    rd(otsc_pkg::OFS_BASIC_FUNC, 32'h6);
    pulse_supply;
    settle(2);
    cmp(32'({fwdPermit, revPermit}), 32'h3);
    rd(otsc_pkg::OFS_STATUS, 32'h00180010);
    drv(1'b0, 1'b0, 1'b0, 1'b0);
    $display("test limit permits done");
    // every stop method, control mode cycling underneath
    for (int m = 0; m < 6; m++) begin
      do_reset;
      controlMode <= 2'(m % 3);
      wr(otsc_pkg::OFS_STOP_METH, 32'(m));
      wr(otsc_pkg::OFS_IRQ_EN, (m == 0) ? 32'h0 : 32'hF);
      pulse_supply;
      drv(1'b0, 1'b0, 1'b1, 1'b1);
      drv(1'b1, 1'b0, 1'b1, 1'b1);
      expMode = (m == 0) ? otsc_pkg::DRV_DBRAKE : (m == 1) ? otsc_pkg::DRV_COAST
                : otsc_pkg::DRV_PLUG;
      cmp(32'(driveMode), 32'(expMode));
      cmp(32'(torqueLimit), 32'h12C);
      cmp(32'(irq), 32'(m != 0));
      cmp(32'(posErrorHold), 32'(m % 3 == 1));
      cmp(32'({fwdPermit, revPermit}), 32'h1);
      rd(otsc_pkg::OFS_IRQ_STAT, 32'h1);
      wr(otsc_pkg::OFS_IRQ_CLR, 32'hF);
      settle(2);
      cmp(32'(irq), 32'h0);
      drv(1'b1, 1'b0, 1'b1, 1'b0);
      expMode = (m > 3) ? otsc_pkg::DRV_CLAMP : otsc_pkg::DRV_COAST;
      cmp(32'(driveMode), 32'(expMode));
      // odd methods back off in reverse; even ones ask both ways and stay
      @(posedge clk);
      motionRequest <= (m % 2 == 1) ? 2'h2 : 2'h3;
      settle(2);
      if (m % 2 == 1) expMode = otsc_pkg::DRV_RUN;
      cmp(32'(driveMode), 32'(expMode));
      @(posedge clk);
      errClr <= 1'b1;
      motionRequest <= 2'h1;
      @(posedge clk);
      errClr <= 1'b0;
      settle(2);
      cmp(32'(posErrorHold), 32'h0);
      drv(1'b0, 1'b0, 1'b1, 1'b0);
      cmp(32'(driveMode), 32'(otsc_pkg::DRV_RUN));
      if (m > 1) begin
        drv(1'b0, 1'b0, 1'b0, 1'b1);
        expMode = (m % 2 == 1) ? otsc_pkg::DRV_COAST : otsc_pkg::DRV_DBRAKE;
        cmp(32'(driveMode), 32'(expMode));
      end
      $display("test stop method %0d done", m);
    end
    // random plug torque and rating, boundary zero first
    do_reset;
    for (int i = 0; i < 8; i++) begin
      rng = xorshift(rng);
      plug = (i == 0) ? 9'h0 : rng[8:0];
      rated = 9'(rng[31:16] % 32'h12D);
      wr(otsc_pkg::OFS_RATED_TQ, 32'(rated));
      wr(otsc_pkg::OFS_PLUG_TQ, 32'(plug));
      settle(2);
      expTq = (plug > 9'h12C) ? 9'h12C : plug;
      rd(otsc_pkg::OFS_PLUG_TQ, 32'(expTq));
      if (rated < expTq) expTq = rated;
      cmp(32'(torqueLimit), 32'(expTq));
    end
    $display("test plug torque done");
    settle(2);
    end_of_test;
  end

  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    $display("wrong value at %0t: run timed out", $time);
    end_of_test;
  end
endmodule
